// >>> design/lpdc_top.sv
// Low-power duty-cycle controller: state machine, turns count, APB registers.
`timescale 1ns/1ps
module lpdc_top #(
  parameter int unsigned PINS_LOW_CYC = lpdc_pkg::PINS_LOW_CYC,
  parameter int unsigned WAKE_CYC = lpdc_pkg::WAKE_CYC,
  parameter int unsigned SLEEP_UNIT_CYC = lpdc_pkg::SLEEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mosi,
  input wire logic sclk,
  input wire logic csn,
  input wire logic wake_cmp,
  input wire logic pll_lock,
  input wire logic [13:0] lp_angle,
  output logic pwm_oe,
  output logic miso_oe,
  output logic commutation_outputs_oe,
  output logic pll_en,
  output logic io_reg_en,
  output logic serial_en,
  output logic analog_pwr_en,
  output logic lp_path_en,
  output logic angle_out_en,
  output logic temp_upd_en,
  output logic lpm_active,
  output logic [15:0] turns_count
);
  typedef struct packed {
    lpdc_pkg::lpdc_state_t st;
    logic [31:0] low_cnt;
    logic [31:0] snap_cnt;
    logic [13:0] prev;
    logic have_prev;
    logic fast;
    logic snap;
    logic [15:0] turns;
    logic lp_en;
    logic transport;
    logic t45;
    logic [13:0] vthr;
    logic [5:0] sleep_sel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic full_io;
    logic pll_on;
    logic analog_on;
    logic lp_on;
    logic lpm;
  } lpdc_st_t;

  lpdc_st_t q;
  lpdc_st_t n;
  logic [4:0] pins_s;
  logic tick;
  logic all_low;
  logic wake_hi;
  logic lock;
  logic quiet;
  logic [13:0] d_ang;
  logic [13:0] mag;
  logic [15:0] step;
  logic [2:0] sec_d;
  logic wr;

  lpdc_sync #(.W(5)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({pll_lock, wake_cmp, csn, sclk, mosi}),
    .q(pins_s)
  );

  lpdc_period #(.UNIT_CYC(SLEEP_UNIT_CYC)) u_period (
    .clk(clk),
    .reset_n(reset_n),
    .sel(q.sleep_sel),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.snap = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    all_low = ~|pins_s[2:0];
    wake_hi = pins_s[3];
    lock = pins_s[4];
    quiet = (q.low_cnt == PINS_LOW_CYC);
    // A write whose access edge finds full power already left is dropped.
    wr = psel && penable && q.pready && pwrite && !q.pslverr &&
         (q.st == lpdc_pkg::ST_FULL); // RQ18
    d_ang = lp_angle - q.prev;
    mag = d_ang[13] ? 14'(-d_ang) : d_ang;
    sec_d = lp_angle[13:11] - q.prev[13:11];
    if (!q.have_prev) begin
      step = 16'h0000;
    end else if (q.t45) begin
      step = {{13{sec_d[2]}}, sec_d}; // RQ17
    end else if (lp_angle[13] != q.prev[13]) begin
      step = d_ang[13] ? 16'hFFFF : 16'h0001; // RQ17
    end else begin
      step = 16'h0000;
    end

    // The 64 us quiet time restarts on any serial pin going high.
    if (!all_low) begin
      n.low_cnt = 32'h00000000;
    end else if (!quiet) begin
      n.low_cnt = q.low_cnt + 32'h00000001; // RQ5
    end

    // Snapshots run back to back while awake; sleep holds the last sample.
    if (q.st == lpdc_pkg::ST_FULL || q.st == lpdc_pkg::ST_WAKE) begin
      if (q.snap_cnt >= WAKE_CYC - 1) begin
        n.snap_cnt = 32'h00000000; // RQ12
        n.snap = 1'b1;
        n.prev = lp_angle; // RQ4
        n.have_prev = 1'b1;
        n.fast = q.have_prev && (mag > q.vthr); // RQ8 RQ9
        n.turns = q.turns + step; // RQ4
      end else begin
        n.snap_cnt = q.snap_cnt + 32'h00000001;
      end
    end else begin
      n.snap_cnt = 32'h00000000; // RQ3
    end

    case (q.st)
      lpdc_pkg::ST_FULL: begin
        if (quiet && (q.lp_en || q.transport) && !wake_hi && !q.fast) begin
          n.st = lpdc_pkg::ST_WAKE; // RQ1 RQ5 RQ14
        end
      end
      lpdc_pkg::ST_WAKE: begin
        if (!all_low) begin
          n.st = lpdc_pkg::ST_SETTLE; // RQ10
        end else if (tick && !q.fast && !wake_hi) begin
          n.st = lpdc_pkg::ST_SLEEP; // RQ6 RQ11 RQ16
        end
      end
      lpdc_pkg::ST_SLEEP: begin
        if (!all_low) begin
          n.st = lpdc_pkg::ST_SETTLE; // RQ10 RQ7
        end else if (tick || wake_hi) begin
          n.st = lpdc_pkg::ST_WAKE; // RQ8 RQ14
        end
      end
      lpdc_pkg::ST_SETTLE: begin
        if (lock) begin
          n.st = lpdc_pkg::ST_FULL; // RQ10 RQ15
        end
      end
      default: begin
        n.st = lpdc_pkg::ST_FULL;
      end
    endcase

    // Outputs follow the next state so they change with the state register.
    n.full_io = (n.st == lpdc_pkg::ST_FULL); // RQ2
    n.pll_on = (n.st == lpdc_pkg::ST_FULL) || (n.st == lpdc_pkg::ST_SETTLE);
    n.analog_on = (n.st != lpdc_pkg::ST_SLEEP); // RQ3
    n.lp_on = (n.st == lpdc_pkg::ST_WAKE); // RQ5
    n.lpm = (n.st == lpdc_pkg::ST_WAKE) || (n.st == lpdc_pkg::ST_SLEEP);
    if (n.st == lpdc_pkg::ST_SLEEP) begin
      n.snap_cnt = 32'h00000000; // RQ3
    end

    // Writes are refused outside full power so configuration stays static.
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.prdata = 32'h00000000;
      case (paddr)
        lpdc_pkg::OFS_CTRL: begin
          n.prdata[lpdc_pkg::CTRL_LP_EN] = q.lp_en;
          n.prdata[lpdc_pkg::CTRL_TRANSPORT] = q.transport;
          n.prdata[lpdc_pkg::CTRL_T45] = q.t45;
        end
        lpdc_pkg::OFS_VTHR: n.prdata[13:0] = q.vthr;
        lpdc_pkg::OFS_SLEEP: n.prdata[5:0] = q.sleep_sel;
        lpdc_pkg::OFS_STATUS: begin
          n.prdata[lpdc_pkg::STAT_STATE +: 4] = q.st;
          n.prdata[lpdc_pkg::STAT_FAST] = q.fast;
          n.prdata[lpdc_pkg::STAT_PINS +: 5] = pins_s;
        end
        lpdc_pkg::OFS_TURNS: n.prdata[15:0] = q.turns;
        default: n.pslverr = 1'b1;
      endcase
      if (pwrite && (q.st != lpdc_pkg::ST_FULL ||
                     paddr == lpdc_pkg::OFS_STATUS ||
                     paddr == lpdc_pkg::OFS_TURNS)) begin
        n.pslverr = 1'b1; // RQ18
      end
    end
    if (wr) begin
      case (paddr)
        lpdc_pkg::OFS_CTRL: begin
          n.lp_en = pwdata[lpdc_pkg::CTRL_LP_EN];
          n.transport = pwdata[lpdc_pkg::CTRL_TRANSPORT];
          n.t45 = pwdata[lpdc_pkg::CTRL_T45];
        end
        lpdc_pkg::OFS_VTHR: n.vthr = pwdata[13:0];
        lpdc_pkg::OFS_SLEEP: n.sleep_sel = pwdata[5:0]; // RQ13
        default: n.lp_en = q.lp_en;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= lpdc_pkg::ST_FULL; // RQ15
      q.vthr <= lpdc_pkg::VTHR_RST;
      q.sleep_sel <= lpdc_pkg::SLEEP_RST;
      q.full_io <= 1'b1;
      q.pll_on <= 1'b1;
      q.analog_on <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pwm_oe = q.full_io;
  assign miso_oe = q.full_io;
  assign commutation_outputs_oe = q.full_io;
  assign angle_out_en = q.full_io;
  assign temp_upd_en = q.full_io;
  assign pll_en = q.pll_on;
  assign io_reg_en = q.pll_on;
  assign serial_en = q.pll_on;
  assign analog_pwr_en = q.analog_on;
  assign lp_path_en = q.lp_on;
  assign lpm_active = q.lpm;
  assign turns_count = q.turns;

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  localparam int PQ = PINS_LOW_CYC;
  localparam int WQ = WAKE_CYC;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_full_to_wake;
    q.st == lpdc_pkg::ST_FULL ##1 q.st == lpdc_pkg::ST_WAKE;
  endsequence
  sequence s_wake_to_sleep;
    q.st == lpdc_pkg::ST_WAKE ##1 q.st == lpdc_pkg::ST_SLEEP;
  endsequence

  property p_entry;
    s_full_to_wake |-> $past(q.lp_en || q.transport) && $past(!q.fast);
  endproperty
  a_entry: assert property (p_entry) else $error("bad LPM entry"); // RQ1

  property p_quiet;
    s_full_to_wake |-> $past(q.low_cnt) == PQ && $past(all_low, 2);
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet time short"); // RQ5

  property p_tristate;
    q.st != lpdc_pkg::ST_FULL |-> !pwm_oe && !miso_oe &&
      !commutation_outputs_oe && !angle_out_en;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins driven"); // RQ2

  property p_sleep_off;
    q.st == lpdc_pkg::ST_SLEEP |-> !analog_pwr_en && q.snap_cnt == 0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("analog on"); // RQ3

  property p_sleep_edge;
    s_wake_to_sleep |-> $past(tick) && $past(!q.fast) && $past(!wake_hi);
  endproperty
  a_sleep_edge: assert property (p_sleep_edge) else $error("bad sleep"); // RQ11

  property p_rewake;
    q.st == lpdc_pkg::ST_SLEEP && all_low && (tick || wake_hi)
      |=> q.st == lpdc_pkg::ST_WAKE && lp_path_en;
  endproperty
  a_rewake: assert property (p_rewake) else $error("no rewake"); // RQ8

  property p_wake_hold;
    q.st == lpdc_pkg::ST_WAKE && wake_hi && all_low
      |=> q.st == lpdc_pkg::ST_WAKE;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("left wake"); // RQ16

  property p_exit;
    (q.st == lpdc_pkg::ST_WAKE || q.st == lpdc_pkg::ST_SLEEP) && !all_low
      |=> q.st == lpdc_pkg::ST_SETTLE ##0 pll_en && !angle_out_en;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit"); // RQ10

  property p_lock;
    q.st == lpdc_pkg::ST_SETTLE && lock |=> angle_out_en && temp_upd_en;
  endproperty
  a_lock: assert property (p_lock) else $error("no resume"); // RQ15

  property p_snap;
    q.snap |-> $past(q.snap_cnt) == WQ - 1;
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot length"); // RQ12

  property p_cfg_hold;
    q.st != lpdc_pkg::ST_FULL && q.st != lpdc_pkg::ST_SETTLE
      |=> $stable(q.vthr) && $stable(q.sleep_sel) && $stable(q.lp_en);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed"); // RQ18
endmodule

// >>> design/lpdc_pkg.sv
// Constants, states and register map of the low-power duty-cycle controller.
// Operation
// RQ1: Enter low power only with pins low, slow angle, WAKE low, mode enabled.
// RQ2: In low power stop angle output, release PWM, tri-state MISO and outputs.
// RQ3: In sleep the analog transducer is unpowered and nothing is measured.
// RQ4: Wake periodically, sample magnet via reduced path, update turns count.
// RQ5: All three serial inputs low 64 us enters wake, full-power logic off.
// RQ6: Wake goes to sleep when velocity and WAKE are both below threshold.
// RQ7: Sleep keeps oscillator, counts sleep period, watches pins and WAKE.
// RQ8: Timer expiry or WAKE returns to wake; turns and velocity are updated.
// RQ9: Velocity above threshold keeps the device awake, counting turns.
// RQ10: Any serial input high leaves low power; wait PLL lock, then resume.
// RQ11: Sleep timer runs always; sleep is entered only at a period end.
// RQ12: Each wake snapshot lasts a fixed 160 us.
// RQ13: Sleep period programmable from 8.192 ms to 524 ms.
// RQ14: Transport code allows low power; WAKE or speed forces wake.
// RQ15: After reset or any serial input high, run in full power.
// RQ16: While WAKE stays high, remain in wake tracking turns, no angles.
// RQ17: Turns count in 45 or 180 degree steps, selected by a field.
// RQ18: Configuration is static: written in full power, held during low power.
package lpdc_pkg;

  typedef enum logic [3:0] {
    ST_FULL = 4'h1,
    ST_WAKE = 4'h2,
    ST_SLEEP = 4'h4,
    ST_SETTLE = 4'h8
  } lpdc_state_t;

  localparam int unsigned CLK_NS = 5;
  localparam int unsigned PINS_LOW_NS = 64000;
  localparam int unsigned WAKE_NS = 160000;
  localparam int unsigned SLEEP_UNIT_NS = 8192000;
  localparam int unsigned PINS_LOW_CYC = (PINS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLEEP_UNIT_CYC =
    (SLEEP_UNIT_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VTHR = 8'h04;
  localparam logic [7:0] OFS_SLEEP = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_TURNS = 8'h10;

  localparam int CTRL_LP_EN = 0;
  localparam int CTRL_TRANSPORT = 1;
  localparam int CTRL_T45 = 2;
  localparam int STAT_STATE = 0;
  localparam int STAT_FAST = 4;
  localparam int STAT_PINS = 8;

  localparam logic [13:0] VTHR_RST = 14'h0040;
  localparam logic [5:0] SLEEP_RST = 6'h00;
  localparam int unsigned ANG_W = 14;
  localparam int unsigned TURNS_W = 16;

endpackage

// >>> design/lpdc_sync.sv
// Three-stage pin synchroniser; a change counts once stages two and three agree.
`timescale 1ns/1ps
module lpdc_sync #(
  parameter int unsigned W = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } lpdc_sync_st_t;

  lpdc_sync_st_t r_q;
  lpdc_sync_st_t r_d;
  logic [W-1:0] agree_o;

  // Stage one is read only by stage two; the filter looks at two and three.
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    assign agree_o[i] = (r_q.s2[i] == r_q.s3[i]) ? r_q.s3[i] : r_q.o[i];
  end

  always_comb begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.o = agree_o;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.o;
endmodule

// >>> design/lpdc_period.sv
// Free-running sleep-period timer giving a one-cycle pulse per period.
`timescale 1ns/1ps
module lpdc_period #(
  parameter int unsigned UNIT_CYC = lpdc_pkg::SLEEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [31:0] unit;
    logic [5:0] mult;
    logic tick;
  } lpdc_per_st_t;

  lpdc_per_st_t r_q;
  lpdc_per_st_t r_d;

  // Period is (sel + 1) units; never restarted, so boundaries stay fixed.
  always_comb begin
    r_d = r_q;
    r_d.tick = 1'b0;
    if (r_q.unit >= UNIT_CYC - 1) begin
      r_d.unit = 32'h00000000;
      if (r_q.mult >= sel) begin
        r_d.mult = 6'h00;
        r_d.tick = 1'b1;
      end else begin
        r_d.mult = r_q.mult + 6'h01;
      end
    end else begin
      r_d.unit = r_q.unit + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign tick = r_q.tick;
endmodule

// >>> dv/lpdc_host.sv
// Host model: serial pin levels and the PLL lock answer.
`timescale 1ns/1ps
module lpdc_host (
  input wire logic clk,
  input wire logic lp_req,
  input wire logic pll_en,
  input wire logic [3:0] lock_dly,
  output logic mosi,
  output logic sclk,
  output logic csn,
  output logic pll_lock
);
  logic [3:0] cnt_q;
  initial begin
    mosi = 1'h0;
    sclk = 1'h0;
    csn = 1'h1;
    pll_lock = 1'h0;
    cnt_q = 4'h0;
  end
  // A deselected data line toggles so a stale level never looks low.
  always @(posedge clk) begin
    mosi <= lp_req ? 1'h0 : !mosi;
    sclk <= 1'h0;
    csn <= !lp_req;
  end
  // Lock is slow on purpose; it drops as soon as the PLL is disabled.
  always @(posedge clk) begin
    cnt_q <= (pll_en && cnt_q != 4'hF) ? cnt_q + 4'h1 :
      (pll_en ? cnt_q : 4'h0);
    pll_lock <= pll_en && (cnt_q >= lock_dly);
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the low-power duty-cycle controller.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] m;
    logic [31:0] e;
    logic er;
  } lpdc_row_t;
  localparam int PL = 20;
  localparam int SU = 50;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wake_cmp = 1'h0;
  logic lp_req = 1'h0;
  logic [3:0] lock_dly = 4'h8;
  logic [13:0] lp_angle = 14'h0;
  logic [31:0] prdata;
  logic [15:0] turns_count;
  logic pready, pslverr, mosi, sclk, csn, pll_lock, pwm_oe, miso_oe;
  logic co_oe, pll_en, io_reg_en, serial_en, analog_pwr_en, lp_path_en;
  logic angle_out_en, temp_upd_en, lpm_active;
  int errors = 0;
  int cmp_count = 0;
  lpdc_row_t rows [10] = '{
    '{1'h0, 8'h00, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'hFFFFFFFF, 32'h40, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 8'h0C, 32'h0, 32'hF, 32'h1, 1'h0},
    '{1'h1, 8'h10, 32'h5, 32'h0, 32'h0, 1'h1},
    '{1'h0, 8'h14, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h1},
    '{1'h1, 8'h04, 32'h10, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'hFFFFFFFF, 32'h10, 1'h0},
    '{1'h1, 8'h08, 32'h1, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'hFFFFFFFF, 32'h1, 1'h0}};

  always #2.5 clk = ~clk;

  lpdc_host host (.clk(clk), .lp_req(lp_req), .pll_en(pll_en),
    .lock_dly(lock_dly), .mosi(mosi), .sclk(sclk), .csn(csn),
    .pll_lock(pll_lock));

  lpdc_top #(.PINS_LOW_CYC(PL), .WAKE_CYC(10), .SLEEP_UNIT_CYC(SU)) dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mosi(mosi), .sclk(sclk),
    .csn(csn), .wake_cmp(wake_cmp), .pll_lock(pll_lock),
    .lp_angle(lp_angle), .pwm_oe(pwm_oe), .miso_oe(miso_oe),
    .commutation_outputs_oe(co_oe), .pll_en(pll_en),
    .io_reg_en(io_reg_en), .serial_en(serial_en),
    .analog_pwr_en(analog_pwr_en), .lp_path_en(lp_path_en),
    .angle_out_en(angle_out_en), .temp_upd_en(temp_upd_en),
    .lpm_active(lpm_active), .turns_count(turns_count));

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs are registered, so values read at an edge are stable ones.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic cfg(input logic [7:0] a, input logic [31:0] d,
      input logic e);
    logic [31:0] rd;
    logic er;
    apb(1'h1, a, d, rd, er);
    check(er, e);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return lpm_active;
      1: return analog_pwr_en;
      2: return pll_en;
      default: return pwm_oe;
    endcase
  endfunction

  task automatic wait_sig(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(sig(k), v);
    if (n >= lim)
      end_of_test();
  endtask

  task automatic run(input int cyc, input logic [13:0] step,
      output int slept);
    slept = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (analog_pwr_en !== 1'h1)
        slept++;
      lp_angle <= lp_angle + step;
    end
  endtask

  initial begin
    logic [31:0] rd;
    logic er;
    int n;
    logic [15:0] t0;
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    check({pwm_oe, pll_en, analog_pwr_en, lp_path_en}, 4'hE);
    check(turns_count, 16'h0);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].wd, rd, er);
      check(er, rows[i].er);
      check(rd & rows[i].m, rows[i].e);
    end
    $display("test registers done");
    lp_req <= 1'h1;
    repeat (4 * PL) @(posedge clk);
    check(lpm_active, 1'h0);
    wake_cmp <= 1'h1;
    // Let the comparator level clear the pin filter before enabling.
    repeat (5) @(posedge clk);
    cfg(8'h00, 32'h1, 1'h0);
    repeat (4 * PL) @(posedge clk);
    check(lpm_active, 1'h0);
    wake_cmp <= 1'h0;
    wait_sig(0, 1'h1, 60);
    check({pwm_oe, miso_oe, co_oe, angle_out_en}, 4'h0);
    check({pll_en, io_reg_en, serial_en, lp_path_en}, 4'h1);
    cfg(8'h00, 32'h0, 1'h1);
    $display("test entry done");
    wait_sig(1, 1'h0, 250);
    check(lp_path_en, 1'h0);
    n = 0;
    while (analog_pwr_en === 1'h0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(n, 2 * SU);
    check(lp_path_en, 1'h1);
    $display("test duty cycle done");
    wait_sig(1, 1'h0, 250);
    t0 = turns_count;
    wake_cmp <= 1'h1;
    wait_sig(1, 1'h1, 10);
    run(100, 14'h0100, n);
    check(n, 0);
    wake_cmp <= 1'h0;
    run(250, 14'h0100, n);
    check(n, 0);
    t0 = turns_count - t0;
    check(t0 >= 16'd9 && t0 <= 16'd11, 1'h1);
    wait_sig(1, 1'h0, 300);
    $display("test stay awake done");
    lp_req <= 1'h0;
    wait_sig(2, 1'h1, 12);
    check({pwm_oe, lpm_active}, 2'h0);
    wait_sig(3, 1'h1, 40);
    check({angle_out_en, temp_upd_en, lpm_active}, 3'h6);
    $display("test exit done");
    cfg(8'h00, 32'h6, 1'h0);
    lp_req <= 1'h1;
    wait_sig(0, 1'h1, 60);
    t0 = turns_count;
    run(40, 14'h0100, n);
    t0 = turns_count - t0;
    check(t0 >= 16'h3 && t0 <= 16'h6, 1'h1);
    lp_req <= 1'h0;
    wait_sig(3, 1'h1, 60);
    $display("test transport done");
    end_of_test();
  end
endmodule
